/* pcc_regs.svh */
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
// ****************************************
// Register offsets (byte addresses = 4 x index)
// ****************************************
`define PCC_IDX_PLL 12'h010
`define PCC_IDX_ABL 12'h017
`define PCC_IDX_CAL 12'h018
`define PCC_IDX_VDIV 12'h1e0
`define PCC_IDX_ROUTE 12'h1e1
`define PCC_IDX_STAT 12'h1f0
`define PCC_IDX_COMMIT 12'h232
// ****************************************
// Field positions
// ****************************************
`define PCC_PWR_LSB 0
`define PCC_CPM_LSB 2
`define PCC_CUR_LSB 4
`define PCC_POL_BIT 7
`define PCC_ROUTE_BYP_BIT 0
`define PCC_ROUTE_VCO_BIT 1
// ****************************************
// Reset values
// ****************************************
`define PCC_RST_PLL 8'h01
`define PCC_RST_ABL 8'h00
`define PCC_RST_CAL 8'h00
`define PCC_RST_VDIV 8'h00
`define PCC_RST_ROUTE 8'h00
// ****************************************
// Codes and timing
// ****************************************
`define PCC_PWR_NORMAL 2'h0
`define PCC_PWR_DOWN 2'h1
`define PCC_CAL_TIME_US 100
`define PCC_CLK_MHZ 50
`define PCC_CAL_CYCLES (`PCC_CAL_TIME_US * `PCC_CLK_MHZ)
`endif

/* pcc_pkg.sv */
package pcc_pkg;
   typedef enum logic [1:0] {PCC_CP_HIZ, PCC_CP_NORMAL, PCC_CP_UP, PCC_CP_DOWN} pcc_cp_mode_t;
   typedef enum {PCC_CAL_IDLE, PCC_CAL_RUN, PCC_CAL_DONE} pcc_cal_state_t;
endpackage

/* pcc_vco_cal.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.svh"
module pcc_vco_cal #(
   parameter int CAL_CYCLES = `PCC_CAL_CYCLES,
   parameter int BAND_W = 6
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic [2:0] target_in,
   output logic busy_out,
   output logic done_out,
   output logic [BAND_W-1:0] band_out
);
   typedef struct packed {
      pcc_pkg::pcc_cal_state_t st;
      logic [31:0] cnt;
      logic [BAND_W-1:0] band;
   } pcc_cal_q_t;
   pcc_cal_q_t s_q, s_d;
   // ****************************************
   // Band selection sequence
   // ****************************************
   always_comb begin
      s_d = s_q;
      unique case (s_q.st)
         pcc_pkg::PCC_CAL_IDLE, pcc_pkg::PCC_CAL_DONE: begin
            if (start_in) begin
               s_d.st = pcc_pkg::PCC_CAL_RUN;
               s_d.cnt = 32'h0;
               s_d.band = '0;
            end
         end
         pcc_pkg::PCC_CAL_RUN: begin
            s_d.cnt = s_q.cnt + 32'h1;
            if (s_q.cnt >= 32'(CAL_CYCLES - 1)) begin
               s_d.st = pcc_pkg::PCC_CAL_DONE;
               s_d.band = BAND_W'({target_in, 3'h0});
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q.st <= pcc_pkg::PCC_CAL_IDLE;
         s_q.cnt <= 32'h0;
         s_q.band <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign busy_out = (s_q.st == pcc_pkg::PCC_CAL_RUN);
   assign done_out = (s_q.st == pcc_pkg::PCC_CAL_DONE);
   assign band_out = s_q.band;
endmodule // pcc_vco_cal
`default_nettype wire

/* pcc_top.sv */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.svh"
// Function
// - Power field 01 holds the PLL in power-down, and this is its reset value.
// - Power field 00 runs the PLL; the pump is active only when the pump mode field is not 00.
// - The bypass bit resets to 0 so distribution uses the divider output.
// - Source bit 0 routes the external clock input to distribution, also at reset.
// - Polarity bit 0 is positive and 1 is negative.
// - Polarity applies only when the external oscillator is in use.
// - A two-bit field sets the antibacklash pulse width.
// - Pump current has eight steps from lowest to highest.
// - Calibration picks the oscillator band for the programmed target.
module pcc_top #(
   parameter int CAL_CYCLES = `PCC_CAL_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [13:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic pll_powered_out,
   output logic pll_powerdown_out,
   output logic pump_active_out,
   output logic [1:0] pump_mode_out,
   output logic [2:0] pump_current_setting_out,
   output logic pfd_invert_out,
   output logic [1:0] antibacklash_width_out,
   output logic [2:0] vco_div_ratio_out,
   output logic dist_bypass_divider_out,
   output logic dist_src_vco_out,
   output logic cal_busy_out,
   output logic [5:0] vco_band_out
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] pll;
      logic [7:0] abl;
      logic [7:0] cal;
      logic [7:0] vdiv;
      logic [7:0] route;
      logic cal_armed;
      logic [31:0] rdata;
      logic [7:0] outs_pll;
      logic [7:0] outs_route;
      logic [7:0] outs_vdiv;
      logic [7:0] outs_abl;
      logic cal_start;
   } pcc_state_t;
   pcc_state_t s_q, s_d;
   logic cal_busy, cal_done;
   logic [5:0] cal_band;
   logic acc, wr_en, rd_en, mapped;
   logic [11:0] idx;
   // ****************************************
   // Bus decode
   // ****************************************
   assign idx = paddr_in[13:2];
   assign acc = psel_in && penable_in;
   assign wr_en = acc && pwrite_in && pstrb_in[0];
   // Read data is loaded at the setup edge so it stands in the access cycle
   assign rd_en = psel_in && !penable_in && !pwrite_in;
   always_comb begin
      unique case (idx)
         `PCC_IDX_PLL, `PCC_IDX_ABL, `PCC_IDX_CAL, `PCC_IDX_VDIV, `PCC_IDX_ROUTE, `PCC_IDX_STAT,
         `PCC_IDX_COMMIT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   // ****************************************
   // Register and commit logic
   // ****************************************
   always_comb begin
      s_d = s_q;
      s_d.cal_start = 1'b0;
      if (wr_en && mapped) begin
         unique case (idx)
            `PCC_IDX_PLL: s_d.pll = pwdata_in[7:0];
            `PCC_IDX_ABL: s_d.abl = pwdata_in[7:0];
            `PCC_IDX_CAL: s_d.cal = pwdata_in[7:0];
            `PCC_IDX_VDIV: s_d.vdiv = pwdata_in[7:0];
            `PCC_IDX_ROUTE: s_d.route = pwdata_in[7:0];
            `PCC_IDX_COMMIT: begin
               if (pwdata_in[0]) begin
                  s_d.outs_pll = s_q.pll;
                  s_d.outs_abl = s_q.abl;
                  s_d.outs_vdiv = s_q.vdiv;
                  s_d.outs_route = s_q.route;
                  // Calibration starts on rising commit of the cal bit
                  if (s_q.cal[0] && !s_q.cal_armed) begin
                     s_d.cal_start = 1'b1;
                     s_d.cal_armed = 1'b1;
                  end else if (!s_q.cal[0]) begin
                     s_d.cal_armed = 1'b0;
                  end
               end
            end
            default: ;
         endcase
      end
      if (rd_en) begin
         unique case (idx)
            `PCC_IDX_PLL: s_d.rdata = {24'h0, s_q.pll};
            `PCC_IDX_ABL: s_d.rdata = {24'h0, s_q.abl};
            `PCC_IDX_CAL: s_d.rdata = {24'h0, s_q.cal};
            `PCC_IDX_VDIV: s_d.rdata = {24'h0, s_q.vdiv};
            `PCC_IDX_ROUTE: s_d.rdata = {24'h0, s_q.route};
            `PCC_IDX_STAT: s_d.rdata = {24'h0, cal_band, cal_done, cal_busy};
            default: s_d.rdata = 32'h0;
         endcase
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q.pll <= `PCC_RST_PLL;
         s_q.abl <= `PCC_RST_ABL;
         s_q.cal <= `PCC_RST_CAL;
         s_q.vdiv <= `PCC_RST_VDIV;
         s_q.route <= `PCC_RST_ROUTE;
         s_q.cal_armed <= 1'b0;
         s_q.rdata <= 32'h0;
         s_q.outs_pll <= `PCC_RST_PLL;
         s_q.outs_abl <= `PCC_RST_ABL;
         s_q.outs_vdiv <= `PCC_RST_VDIV;
         s_q.outs_route <= `PCC_RST_ROUTE;
         s_q.cal_start <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end
   // ****************************************
   // Calibration engine
   // ****************************************
   pcc_vco_cal #(
      .CAL_CYCLES(CAL_CYCLES),
      .BAND_W(6)
   ) u_cal (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .start_in(s_q.cal_start),
      .target_in(s_q.outs_vdiv[2:0]),
      .busy_out(cal_busy),
      .done_out(cal_done),
      .band_out(cal_band)
   );
   // ****************************************
   // Outputs
   // ****************************************
   assign prdata_out = s_q.rdata;
   assign pready_out = 1'b1;
   assign pslverr_out = acc && !mapped;
   assign pll_powerdown_out = (s_q.outs_pll[1:0] == `PCC_PWR_DOWN);
   assign pll_powered_out = (s_q.outs_pll[1:0] == `PCC_PWR_NORMAL);
   assign pump_active_out = pll_powered_out && (s_q.outs_pll[3:2] != 2'h0);
   assign pump_mode_out = s_q.outs_pll[`PCC_CPM_LSB +: 2];
   assign pump_current_setting_out = s_q.outs_pll[`PCC_CUR_LSB +: 3];
   // Polarity ignored with the internal oscillator
   assign pfd_invert_out = s_q.outs_pll[`PCC_POL_BIT] && !s_q.outs_route[`PCC_ROUTE_VCO_BIT];
   assign antibacklash_width_out = s_q.outs_abl[1:0];
   assign vco_div_ratio_out = s_q.outs_vdiv[2:0];
   assign dist_bypass_divider_out = s_q.outs_route[`PCC_ROUTE_BYP_BIT];
   assign dist_src_vco_out = s_q.outs_route[`PCC_ROUTE_VCO_BIT];
   assign cal_busy_out = cal_busy;
   assign vco_band_out = cal_band;
   // ****************************************
   // Checks
   // ****************************************
   property p_pwr_reset;
      @(posedge ref_clk_in) $fell(rst_in) |-> pll_powerdown_out && !dist_src_vco_out && !dist_bypass_divider_out;
   endproperty
   a_pwr_reset: assert property (p_pwr_reset) else $error("bad reset routing");
   property p_pwr_on;
      @(posedge ref_clk_in) disable iff (rst_in) pll_powered_out |-> !pll_powerdown_out && s_q.outs_pll[1:0] == 2'h0;
   endproperty
   a_pwr_on: assert property (p_pwr_on) else $error("power state wrong");
   property p_vdiv_reset;
      @(posedge ref_clk_in) $fell(rst_in) |-> vco_div_ratio_out == 3'h0;
   endproperty
   a_vdiv_reset: assert property (p_vdiv_reset) else $error("divider not reset");
   property p_pol_int;
      @(posedge ref_clk_in) disable iff (rst_in) dist_src_vco_out |-> !pfd_invert_out;
   endproperty
   a_pol_int: assert property (p_pol_int) else $error("polarity used with internal vco");
   property p_pol_ext;
      @(posedge ref_clk_in) disable iff (rst_in) !dist_src_vco_out |-> pfd_invert_out == s_q.outs_pll[7];
   endproperty
   a_pol_ext: assert property (p_pol_ext) else $error("polarity not applied");
   sequence s_commit;
      wr_en && idx == `PCC_IDX_COMMIT && pwdata_in[0];
   endsequence
   property p_commit_abl;
      @(posedge ref_clk_in) disable iff (rst_in) s_commit |=> antibacklash_width_out == $past(s_q.abl[1:0]);
   endproperty
   a_commit_abl: assert property (p_commit_abl) else $error("antibacklash not committed");
   property p_commit_mode;
      @(posedge ref_clk_in) disable iff (rst_in) s_commit |=> pump_mode_out == $past(s_q.pll[3:2]) &&
         pump_current_setting_out == $past(s_q.pll[6:4]);
   endproperty
   a_commit_mode: assert property (p_commit_mode) else $error("pump fields not committed");
   property p_cal_start;
      @(posedge ref_clk_in) disable iff (rst_in) s_q.cal_start |=> cal_busy_out;
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
   property p_wr_keep;
      @(posedge ref_clk_in) disable iff (rst_in) wr_en && idx == `PCC_IDX_CAL |=> s_q.cal == $past(pwdata_in[7:0]);
   endproperty
   a_wr_keep: assert property (p_wr_keep) else $error("register lost write");
endmodule // pcc_top
`default_nettype wire

/* tb_pcc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.svh"
module tb_top;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [13:0] paddr_in = 14'h0000;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic [3:0] pstrb_in = 4'h0;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, pll_powered_out, pll_powerdown_out, pump_active_out;
   logic [1:0] pump_mode_out, antibacklash_width_out;
   logic [2:0] pump_current_setting_out, vco_div_ratio_out;
   logic pfd_invert_out, dist_bypass_divider_out, dist_src_vco_out, cal_busy_out;
   logic [5:0] vco_band_out;
   logic [31:0] rd;
   logic err, hit;
   int n_fail = 0;
   int n_checks = 0;
   always #10 ref_clk_in = ~ref_clk_in;
   pcc_top #(.CAL_CYCLES(10)) DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .pll_powered_out(pll_powered_out), .pll_powerdown_out(pll_powerdown_out),
      .pump_active_out(pump_active_out), .pump_mode_out(pump_mode_out),
      .pump_current_setting_out(pump_current_setting_out), .pfd_invert_out(pfd_invert_out),
      .antibacklash_width_out(antibacklash_width_out), .vco_div_ratio_out(vco_div_ratio_out),
      .dist_bypass_divider_out(dist_bypass_divider_out), .dist_src_vco_out(dist_src_vco_out),
      .cal_busy_out(cal_busy_out), .vco_band_out(vco_band_out));
   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************************************
   // Bus master
   // ****************************************
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] s);
      int k;
      @(posedge ref_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= {idx, 2'b00};
      pwdata_in <= {24'h00_0000, d};
      pstrb_in <= s;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge ref_clk_in);
         if (pready_out === 1'b1) break;
      end
      if (k == 20) begin
         n_fail++;
         give_verdict();
      end
      err = pslverr_out;
      rd = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 4'hf);
   endtask
   task automatic rdchk(input logic [11:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00, 4'h0);
      chk(rd, {24'h00_0000, e});
   endtask
   task automatic commit;
      wr(`PCC_IDX_COMMIT, 8'h01);
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic wait_for(input logic lvl, input int n);
      hit = 1'b0;
      repeat (n) begin
         @(posedge ref_clk_in);
         #1 if (cal_busy_out === lvl) hit = 1'b1;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      rdchk(`PCC_IDX_PLL, 8'h01);
      rdchk(`PCC_IDX_VDIV, 8'h00);
      rdchk(`PCC_IDX_ROUTE, 8'h00);
      chk(pll_powerdown_out, 1'b1);
      chk(pll_powered_out, 1'b0);
      chk(vco_div_ratio_out, 3'h0);
      chk(dist_bypass_divider_out, 1'b0);
      chk(dist_src_vco_out, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_pump;
      for (int i = 0; i < 8; i++) begin
         wr(`PCC_IDX_PLL, {i[0], i[2:0], i[1:0], 2'b00});
         wr(`PCC_IDX_ABL, {6'h00, i[1:0]});
         chk(pump_current_setting_out, (i == 0) ? 3'h0 : 3'(i - 1));
         commit();
         chk(pll_powered_out, 1'b1);
         chk(pll_powerdown_out, 1'b0);
         chk(pump_mode_out, i[1:0]);
         chk(pump_active_out, i[1:0] != 2'h0);
         chk(pump_current_setting_out, i[2:0]);
         chk(pfd_invert_out, i[0]);
         chk(antibacklash_width_out, i[1:0]);
      end
      $display("test pump done");
   endtask
   task automatic t_route;
      wr(`PCC_IDX_ROUTE, 8'h03);
      wr(`PCC_IDX_VDIV, 8'hf5);
      commit();
      chk(dist_src_vco_out, 1'b1);
      chk(dist_bypass_divider_out, 1'b1);
      chk(vco_div_ratio_out, 3'h5);
      chk(pfd_invert_out, 1'b0);
      rdchk(`PCC_IDX_VDIV, 8'hf5);
      apb(1'b1, `PCC_IDX_VDIV, 8'h33, 4'h0);
      rdchk(`PCC_IDX_VDIV, 8'hf5);
      apb(1'b1, 12'h100, 8'h55, 4'hf);
      chk(err, 1'b1);
      wr(`PCC_IDX_ROUTE, 8'h00);
      commit();
      chk(pfd_invert_out, 1'b1);
      $display("test route done");
   endtask
   task automatic t_cal;
      wr(`PCC_IDX_CAL, 8'h01);
      commit();
      wait_for(1'b1, 6);
      chk(hit, 1'b1);
      wait_for(1'b0, 40);
      chk(hit, 1'b1);
      chk(vco_band_out, 6'h28);
      apb(1'b0, `PCC_IDX_STAT, 8'h00, 4'h0);
      chk(rd[7:2], 6'h28);
      commit();
      wait_for(1'b1, 8);
      chk(hit, 1'b0);
      wr(`PCC_IDX_CAL, 8'h00);
      commit();
      wr(`PCC_IDX_CAL, 8'h01);
      commit();
      wait_for(1'b1, 6);
      chk(hit, 1'b1);
      wait_for(1'b0, 40);
      $display("test calibration done");
   endtask
   task automatic t_down;
      wr(`PCC_IDX_PLL, 8'h0d);
      commit();
      chk(pll_powerdown_out, 1'b1);
      chk(pll_powered_out, 1'b0);
      chk(pump_active_out, 1'b0);
      $display("test power down done");
   endtask
   initial begin
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_pump();
      t_route();
      t_cal();
      t_down();
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
